// File: design/charger_regs_consts.svh
`ifndef CHARGER_REGS_CONSTS_SVH
`define CHARGER_REGS_CONSTS_SVH

// register offsets on the serial port
`define ADDR_FS2        8'h08
`define ADDR_IEN        8'h09
`define ADDR_IACT       8'h0A

// reset values
`define FS2_RST         8'h00
`define IEN_RST         7'h00
`define IACT_RST        7'h00

// settings register field positions
`define FS2_COMP_BIT    7
`define FS2_CHOICE_BIT  6
`define FS2_VLIM_BIT    5
`define FS2_DIODE_HI    4
`define FS2_DIODE_LO    3
`define FS2_RAIL_HI     2
`define FS2_RAIL_LO     0

// ideal diode mode codes; other codes disable the diode
`define DIODE_ALWAYS    2'h0
`define DIODE_WEAK      2'h1

// system rail: base and step in millivolts
`define RAIL_BASE_MV    13'h10CC
`define RAIL_STEP_MV    13'h0064

// flag and enable bit positions (shared by both registers)
`define FLG_THERM       6
`define FLG_WD          5
`define FLG_OT          4
`define FLG_THR         3
`define FLG_BAT         2
`define FLG_MODE        1
`define FLG_VIN         0

// timing: clock rate in Hz, one watchdog tick in seconds
`define CLK_HZ          10000000
`define SEC_TIME        1
// watchdog periods and alarm lead, in seconds
`define WD_SHORT_S      7'h20
`define WD_LONG_S       7'h40
`define WD_SHORT_LEAD_S 7'h02
`define WD_LONG_LEAD_S  7'h04

// serial port: bits per byte, default device address (arbitrary value)
`define BYTE_BITS       4'h8
`define LAST_BIT        4'h7
`define DEV_ADDR_DFLT   7'h2A

`endif

// File: design/charger_regs_pkg.sv
package charger_regs_pkg;

	// serial port engine states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACKO = 5'h04,
		ST_TX   = 5'h08,
		ST_ACKI = 5'h10
	} i2c_state_t;

	// meaning of the next received byte
	typedef enum logic [2:0] {
		K_ADDR = 3'h1,
		K_PTR  = 3'h2,
		K_DATA = 3'h4
	} kind_t;

	// whole state of the register block
	typedef struct packed {
		i2c_state_t  st;
		kind_t       kind;
		logic        rw;
		logic        nack;
		logic [3:0]  bitc;
		logic [7:0]  sh;
		logic [7:0]  ptr;
		logic        sda_oe_n;
		logic        sda_lvl;
		logic        scl_p;
		logic        sda_p;
		logic [7:0]  fs2;
		logic [6:0]  ien;
		logic [6:0]  act;
		logic        irq;
		logic        therm_p;
		logic        ot_p;
		logic [2:0]  thr_p;
		logic [2:0]  bat_p;
		logic [2:0]  mode_p;
		logic [1:0]  vin_p;
		logic        permit;
		logic        diode_on;
		logic [12:0] rail_mv;
		logic [23:0] tick;
		logic [6:0]  wd_secs;
		logic        wd_exp;
	} state_t;

endpackage : charger_regs_pkg

// File: design/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of pin levels
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         nrst_i,
	// levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	// both stages as one state word
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t r;
	sync_t n;

	// first stage feeds only the second
	always_comb begin
		n.s1 = d_i;
		n.s2 = r.s1;
	end

	// registers; constant reset value only
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign q_o = r.s2;
endmodule : pin_sync

// File: design/charger_config_and_irq_regs.sv
`timescale 1ns/1ps
`include "charger_regs_consts.svh"
module charger_config_and_irq_regs #(
	parameter logic [6:0]  DEV_ADDR   = `DEV_ADDR_DFLT,
	parameter int unsigned SEC_CYCLES = `CLK_HZ * `SEC_TIME
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	// serial port pins
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n_o,
	// analog status levels (asynchronous)
	input  wire logic        thermal_limit_i,
	input  wire logic        overtemp_i,
	input  wire logic [2:0]  thermistor_zone_i,
	input  wire logic [2:0]  battery_zone_i,
	input  wire logic [2:0]  charger_mode_i,
	input  wire logic [1:0]  supply_zone_i,
	input  wire logic        battery_below_limit_i,
	input  wire logic        system_below_battery_i,
	input  wire logic        battery_above_weak_i,
	// watchdog control from timer logic (same clock)
	input  wire logic        watchdog_enable_i,
	input  wire logic        watchdog_period_select_i,
	input  wire logic        watchdog_kick_i,
	// settings to the charger
	output logic             temp_profile_compliance_enable_o,
	output logic             temp_profile_choice_o,
	output logic             charge_voltage_limit_enable_o,
	output logic [1:0]       ideal_diode_mode_o,
	output logic [2:0]       system_rail_code_o,
	output logic             charge_permit_o,
	output logic             ideal_diode_on_o,
	output logic [12:0]      system_rail_mv_o,
	// watchdog and interrupt
	output logic             watchdog_expired_o,
	output logic             irq_o
);
	// reset image; idle port with line released
	localparam charger_regs_pkg::state_t RST = '{
		st:       charger_regs_pkg::ST_IDLE,
		kind:     charger_regs_pkg::K_ADDR,
		sda_oe_n: 1'b1,
		fs2:      `FS2_RST,
		ien:      `IEN_RST,
		act:      `IACT_RST,
		permit:   1'b1,
		rail_mv:  `RAIL_BASE_MV,
		default:  '0
	};

	charger_regs_pkg::state_t r;   // registered state
	charger_regs_pkg::state_t n;   // next state

	logic [17:0] s;                // synchronised pins
	logic        s_scl;
	logic        s_sda;
	logic        scl_rise;         // edges of the serial clock
	logic        scl_fall;
	logic        start_c;          // start and stop conditions
	logic        stop_c;
	logic        wr_en;            // data byte to commit
	logic        tx_load;          // fetch next read byte
	logic [7:0]  rd_val;           // read mux output
	logic [6:0]  clr;              // flags read out this cycle
	logic [6:0]  ev;               // flag set events
	logic        tick;             // one-second enable
	logic [6:0]  watchdog_period_select;
	logic [6:0]  wd_alarm_at;
	logic        wd_alarm;
	logic [6:0]  secs_nxt;

	// serial and status pin levels pass two flops before use; the watchdog inputs do not
	pin_sync #(.W(18)) u_sync (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.d_i        ({scl_i, sda_i, thermal_limit_i, overtemp_i,
		              thermistor_zone_i, battery_zone_i, charger_mode_i,
		              supply_zone_i, battery_below_limit_i,
		              system_below_battery_i, battery_above_weak_i}),
		.q_o        (s)
	);
	assign s_scl = s[17];
	assign s_sda = s[16];

	// next-state logic for port, registers, flags and watchdog
	always_comb begin
		n        = r;
		scl_rise = s_scl & ~r.scl_p;
		scl_fall = ~s_scl & r.scl_p;
		// sda moving while scl high marks start or stop
		start_c  = s_scl & r.scl_p & r.sda_p & ~s_sda;
		stop_c   = s_scl & r.scl_p & ~r.sda_p & s_sda;
		wr_en    = 1'b0;
		tx_load  = 1'b0;
		clr      = '0;
		n.scl_p  = s_scl;
		n.sda_p  = s_sda;
		// read mux; unmapped offsets and unused bits read zero
		case (r.ptr)
			`ADDR_FS2:  rd_val = r.fs2;
			`ADDR_IEN:  rd_val = {1'b0, r.ien};
			`ADDR_IACT: rd_val = {1'b0, r.act};
			default:    rd_val = 8'h00;
		endcase

		if (start_c) begin
			n.st       = charger_regs_pkg::ST_RX;
			n.kind     = charger_regs_pkg::K_ADDR;
			n.bitc     = '0;
			n.sda_oe_n = 1'b1;
		end else if (stop_c) begin
			n.st       = charger_regs_pkg::ST_IDLE;
			n.sda_oe_n = 1'b1;
		end else begin
			unique case (r.st)
				charger_regs_pkg::ST_IDLE: begin
					n.sda_oe_n = 1'b1;
				end
				charger_regs_pkg::ST_RX: begin
					// sample on rise, act on the fall after bit 8
					if (scl_rise) begin
						n.sh   = {r.sh[6:0], s_sda};
						n.bitc = 4'(r.bitc + 4'h1);
					end
					if (scl_fall && r.bitc == `BYTE_BITS) begin
						n.st       = charger_regs_pkg::ST_ACKO;
						n.sda_oe_n = 1'b0;
						unique case (r.kind)
							charger_regs_pkg::K_ADDR: begin
								n.rw   = r.sh[0];
								n.kind = charger_regs_pkg::K_PTR;
								// foreign address: stay off the line
								if (r.sh[7:1] != DEV_ADDR) begin
									n.st       = charger_regs_pkg::ST_IDLE;
									n.sda_oe_n = 1'b1;
								end
							end
							charger_regs_pkg::K_PTR: begin
								n.ptr  = r.sh;
								n.kind = charger_regs_pkg::K_DATA;
							end
							default: begin
								wr_en = 1'b1;
								n.ptr = 8'(r.ptr + 8'h01);
							end
						endcase
					end
				end
				charger_regs_pkg::ST_ACKO: begin
					// release ack, then either read or receive
					if (scl_fall) begin
						n.bitc     = '0;
						n.sda_oe_n = 1'b1;
						n.st       = charger_regs_pkg::ST_RX;
						tx_load    = r.rw;
					end
				end
				charger_regs_pkg::ST_TX: begin
					if (scl_fall) begin
						if (r.bitc == `LAST_BIT) begin
							n.st       = charger_regs_pkg::ST_ACKI;
							n.sda_oe_n = 1'b1;
						end else begin
							n.sh       = {r.sh[6:0], 1'b0};
							n.sda_oe_n = r.sh[6];
							n.bitc     = 4'(r.bitc + 4'h1);
						end
					end
				end
				charger_regs_pkg::ST_ACKI: begin
					// controller nack ends the read burst
					if (scl_rise) begin
						n.nack = s_sda;
					end
					if (scl_fall) begin
						n.st    = charger_regs_pkg::ST_IDLE;
						tx_load = ~r.nack;
					end
				end
				default: begin
					n.st       = charger_regs_pkg::ST_IDLE;
					n.sda_oe_n = 1'b1;
				end
			endcase
		end

		// load a read byte; msb drives at once, pointer advances
		if (tx_load) begin
			n.st       = charger_regs_pkg::ST_TX;
			n.bitc     = '0;
			n.sh       = rd_val;
			n.sda_oe_n = rd_val[7];
			n.ptr      = 8'(r.ptr + 8'h01);
			if (r.ptr == `ADDR_IACT) begin
				clr = r.act;  // flags clear on being read
			end
		end

		// register writes; the flag register ignores writes
		if (wr_en && r.ptr == `ADDR_FS2) begin
			n.fs2 = r.sh;
		end
		if (wr_en && r.ptr == `ADDR_IEN) begin
			n.ien = r.sh[6:0];
		end

		// watchdog: one-second ticks, counted while enabled
		tick        = (r.tick == 24'(SEC_CYCLES - 1));
		n.tick      = tick ? 24'h000000 : 24'(r.tick + 24'h000001);
		watchdog_period_select   = watchdog_period_select_i ? `WD_LONG_S
		                                       : `WD_SHORT_S;
		wd_alarm_at = watchdog_period_select_i
		              ? 7'(`WD_LONG_S - `WD_LONG_LEAD_S)
		              : 7'(`WD_SHORT_S - `WD_SHORT_LEAD_S);
		secs_nxt    = 7'(r.wd_secs + 7'h01);
		wd_alarm    = 1'b0;
		if (!watchdog_enable_i || watchdog_kick_i) begin
			n.wd_secs = '0;
			n.wd_exp  = 1'b0;
		end else if (tick && !r.wd_exp) begin
			n.wd_secs = secs_nxt;
			wd_alarm  = (secs_nxt == wd_alarm_at);
			n.wd_exp  = (secs_nxt == watchdog_period_select);
		end

		// flag events from edges and code changes
		ev                = '0;
		ev[`FLG_THERM]    = s[15] & ~r.therm_p;
		ev[`FLG_WD]       = wd_alarm;
		ev[`FLG_OT]       = s[14] & ~r.ot_p;
		ev[`FLG_THR]      = (s[13:11] != r.thr_p);
		ev[`FLG_BAT]      = (s[10:8] != r.bat_p);
		ev[`FLG_MODE]     = (s[7:5] != r.mode_p);
		ev[`FLG_VIN]      = (s[4:3] != r.vin_p);
		n.therm_p         = s[15];
		n.ot_p            = s[14];
		n.thr_p           = s[13:11];
		n.bat_p           = s[10:8];
		n.mode_p          = s[7:5];
		n.vin_p           = s[4:3];
		// enabled events set flags; a set beats a same-cycle clear
		n.act = (r.act & ~clr) | (ev & r.ien);
		n.irq = |n.act;

		// derived charger controls
		n.permit   = ~(r.fs2[`FS2_VLIM_BIT] & ~s[2]);
		unique case (r.fs2[`FS2_DIODE_HI:`FS2_DIODE_LO])
			`DIODE_ALWAYS: n.diode_on = s[1];
			`DIODE_WEAK:   n.diode_on = s[1] & s[0];
			default:       n.diode_on = 1'b0;
		endcase
		n.rail_mv  = 13'(`RAIL_BASE_MV + `RAIL_STEP_MV
		             * {10'h000, r.fs2[`FS2_RAIL_HI:`FS2_RAIL_LO]});
		n.sda_lvl  = 1'b0;  // open drain only ever pulls low
	end

	// single state register
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= RST;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state flops
	assign sda_o                            = r.sda_lvl;
	assign sda_oe_n_o                       = r.sda_oe_n;
	assign temp_profile_compliance_enable_o = r.fs2[`FS2_COMP_BIT];
	assign temp_profile_choice_o            = r.fs2[`FS2_CHOICE_BIT];
	assign charge_voltage_limit_enable_o    = r.fs2[`FS2_VLIM_BIT];
	assign ideal_diode_mode_o = r.fs2[`FS2_DIODE_HI:`FS2_DIODE_LO];
	assign system_rail_code_o = r.fs2[`FS2_RAIL_HI:`FS2_RAIL_LO];
	assign charge_permit_o                  = r.permit;
	assign ideal_diode_on_o                 = r.diode_on;
	assign system_rail_mv_o                 = r.rail_mv;
	assign watchdog_expired_o               = r.wd_exp;
	assign irq_o                            = r.irq;

	// checks on the block's own behaviour
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence ack_drive;
		!sda_oe_n_o && r.st == charger_regs_pkg::ST_ACKO;
	endsequence

	addr_ack_a: assert property (  // address match is acknowledged
		(r.st == charger_regs_pkg::ST_RX && scl_fall && !start_c
		 && !stop_c && r.bitc == `BYTE_BITS
		 && r.kind == charger_regs_pkg::K_ADDR && r.sh[7:1] == DEV_ADDR)
		|=> ack_drive)
		else $error("address byte not acknowledged");
	settings_wr_a: assert property (
		(wr_en && r.ptr == `ADDR_FS2) |=>
		(temp_profile_compliance_enable_o == $past(r.sh[7])
		 && temp_profile_choice_o == $past(r.sh[6])
		 && system_rail_code_o == $past(r.sh[2:0])))
		else $error("settings write not applied");
	permit_gate_a: assert property (
		charge_voltage_limit_enable_o && !s[2] |=> !charge_permit_o)
		else $error("charging not withheld above limit");
	diode_off_a: assert property (
		ideal_diode_mode_o[1] |=> !ideal_diode_on_o)
		else $error("ideal diode on while disabled");
	rail_mv_a: assert property (
		##1 system_rail_mv_o == 13'(`RAIL_BASE_MV + `RAIL_STEP_MV
		* {10'h000, $past(system_rail_code_o)}))
		else $error("rail millivolts wrong");
	enable_wr_a: assert property (
		(wr_en && r.ptr == `ADDR_IEN) |=> r.ien == $past(r.sh[6:0]))
		else $error("enable write not applied");
	flag_gate_a: assert property (
		##1 ((r.act & ~$past(r.act) & ~$past(r.ien)) == 7'h00))
		else $error("flag set while its enable is clear");
	wd_alarm_a: assert property (
		$rose(r.act[`FLG_WD]) |-> r.wd_secs == $past(wd_alarm_at))
		else $error("watchdog alarm at wrong second");
	mode_flag_a: assert property (
		(s[7:5] != r.mode_p) && r.ien[`FLG_MODE] |=> r.act[`FLG_MODE])
		else $error("mode change flag not set");
	irq_level_a: assert property (
		$fell(|r.act) |-> ##0 !irq_o ##1 !irq_o || |r.act)
		else $error("interrupt output not following flags");
endmodule : charger_config_and_irq_regs

// File: verif/i2c_host_model.sv
`timescale 1ns/1ps
`include "charger_regs_consts.svh"
// bus controller model; both lines open drain, released means pulled high
module i2c_host_model #(
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DFLT
) (
	// clock
	input  wire logic core_clk_i,
	// resolved data line
	input  wire logic sda_line_i,
	// line drive, 1 = released
	output logic      scl_o,
	output logic      sda_o
);
	// both lines released until the first frame
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// whole clocks; every line change lands just after an edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : tick

	// start or repeated start; ends with the clock low
	task automatic start();
		sda_o <= 1'b1;
		tick(5);
		scl_o <= 1'b1;
		tick(5);
		sda_o <= 1'b0;
		tick(5);
		scl_o <= 1'b0;
		tick(1);
	endtask : start

	// stop: data rises while the clock is high
	task automatic stop();
		sda_o <= 1'b0;
		tick(5);
		scl_o <= 1'b1;
		tick(5);
		sda_o <= 1'b1;
		tick(5);
	endtask : stop

	// one bit; 5-clock phases leave room for the 3-clock answer delay
	task automatic bit_io(input logic b, output logic r);
		sda_o <= b;
		tick(5);
		scl_o <= 1'b1;
		tick(3);
		#1 r = sda_line_i;
		tick(2);
		scl_o <= 1'b0;
		tick(1);
	endtask : bit_io

	// byte msb first, then the acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic ak,
		output logic [7:0] rx, output logic nak);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ak, nak);
	endtask : xfer

	// register write; ok only when all three bytes were acknowledged
	task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] dat, output logic ok);
		logic [7:0] rx;
		logic [2:0] n;
		start();
		xfer({dev, 1'b0}, 1'b1, rx, n[0]);
		xfer(ptr, 1'b1, rx, n[1]);
		xfer(dat, 1'b1, rx, n[2]);
		stop();
		ok = (n === 3'h0);
	endtask : wr_reg

	// register read via repeated start; the single byte is not acknowledged
	task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] dat,
		output logic ok);
		logic [7:0] rx;
		logic [2:0] n;
		logic       last;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, rx, n[0]);
		xfer(ptr, 1'b1, rx, n[1]);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, rx, n[2]);
		xfer(8'hFF, 1'b1, dat, last);
		stop();
		ok = (n === 3'h0);
	endtask : rd_reg

	// two-byte read burst: first byte acknowledged, second not
	task automatic rd_two(input logic [7:0] ptr, output logic [15:0] dat,
		output logic ok);
		logic [7:0] rx;
		logic [2:0] n;
		logic       last;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, rx, n[0]);
		xfer(ptr, 1'b1, rx, n[1]);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, rx, n[2]);
		xfer(8'hFF, 1'b0, dat[15:8], last);
		xfer(8'hFF, 1'b1, dat[7:0], last);
		stop();
		ok = (n === 3'h0);
	endtask : rd_two
endmodule : i2c_host_model

// File: verif/test_charger_config_and_irq_regs.sv
`timescale 1ns/1ps
`include "charger_regs_consts.svh"
module test_charger_config_and_irq_regs;
	// short second keeps the watchdog run brief
	localparam int         SEC_CYC = 20;
	localparam logic [6:0] DEV     = `DEV_ADDR_DFLT;

	// settings value, then sbb abw bbl inputs, then diode and permit
	typedef struct packed {
		logic [7:0] val;
		logic       sbb;
		logic       abw;
		logic       bbl;
		logic       dio;
		logic       prm;
	} row_t;

	// clock, reset, lines
	logic       core_clk_i;
	logic       nrst_i;
	logic       host_scl;
	logic       host_sda;
	logic       sda_line;
	// status and watchdog inputs
	logic       thermal_limit_i;
	logic       overtemp_i;
	logic [2:0] thermistor_zone_i;
	logic [2:0] battery_zone_i;
	logic [2:0] charger_mode_i;
	logic [1:0] supply_zone_i;
	logic       battery_below_limit_i;
	logic       system_below_battery_i;
	logic       battery_above_weak_i;
	logic       watchdog_enable_i;
	logic       watchdog_period_select_i;
	logic       watchdog_kick_i;
	// design outputs
	logic        sda_o;
	logic        sda_oe_n_o;
	logic        temp_profile_compliance_enable_o;
	logic        temp_profile_choice_o;
	logic        charge_voltage_limit_enable_o;
	logic [1:0]  ideal_diode_mode_o;
	logic [2:0]  system_rail_code_o;
	logic        charge_permit_o;
	logic        ideal_diode_on_o;
	logic [12:0] system_rail_mv_o;
	logic        watchdog_expired_o;
	logic        irq_o;
	logic [7:0]  fs2_pins;
	// bench state
	int          n_mismatch;
	int          cmp_count;
	int          t0;
	int          t1;
	logic [7:0]  rd;
	logic [15:0] rd2;              // two-byte burst read
	logic        ok;
	row_t        rows [8] = '{{8'h00, 5'h13}, {8'h09, 5'h11}, {8'h0A, 5'h1B},
		{8'h13, 5'h19}, {8'h1C, 5'h1D}, {8'h25, 5'h08}, {8'h66, 5'h1F},
		{8'h87, 5'h01}};

	// wired-and data line: the device only ever pulls low
	assign sda_line = host_sda & (sda_oe_n_o | sda_o);
	// settings outputs packed in register order
	assign fs2_pins = {temp_profile_compliance_enable_o, temp_profile_choice_o,
		charge_voltage_limit_enable_o, ideal_diode_mode_o, system_rail_code_o};

	charger_config_and_irq_regs #(
		.DEV_ADDR  (DEV),
		.SEC_CYCLES(SEC_CYC)
	) uut (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.scl_i(host_scl),
		.sda_i(sda_line),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.thermal_limit_i(thermal_limit_i),
		.overtemp_i(overtemp_i),
		.thermistor_zone_i(thermistor_zone_i),
		.battery_zone_i(battery_zone_i),
		.charger_mode_i(charger_mode_i),
		.supply_zone_i(supply_zone_i),
		.battery_below_limit_i(battery_below_limit_i),
		.system_below_battery_i(system_below_battery_i),
		.battery_above_weak_i(battery_above_weak_i),
		.watchdog_enable_i(watchdog_enable_i),
		.watchdog_period_select_i(watchdog_period_select_i),
		.watchdog_kick_i(watchdog_kick_i),
		.temp_profile_compliance_enable_o(temp_profile_compliance_enable_o),
		.temp_profile_choice_o(temp_profile_choice_o),
		.charge_voltage_limit_enable_o(charge_voltage_limit_enable_o),
		.ideal_diode_mode_o(ideal_diode_mode_o),
		.system_rail_code_o(system_rail_code_o),
		.charge_permit_o(charge_permit_o),
		.ideal_diode_on_o(ideal_diode_on_o),
		.system_rail_mv_o(system_rail_mv_o),
		.watchdog_expired_o(watchdog_expired_o),
		.irq_o(irq_o)
	);

	i2c_host_model #(.DEV_ADDR(DEV)) host (
		.core_clk_i(core_clk_i),
		.sda_line_i(sda_line),
		.scl_o     (host_scl),
		.sda_o     (host_sda)
	);

	// 100 ns clock
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	// compare, counting; x never matches
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one event per flag position except the watchdog; levels rise, codes step
	task automatic fire(input int b);
		case (b)
			`FLG_THERM: thermal_limit_i <= 1'b1;
			`FLG_OT:    overtemp_i <= 1'b1;
			`FLG_THR:   thermistor_zone_i <= thermistor_zone_i + 3'h1;
			`FLG_BAT:   battery_zone_i <= battery_zone_i + 3'h1;
			`FLG_MODE:  charger_mode_i <= charger_mode_i + 3'h1;
			`FLG_VIN:   supply_zone_i <= supply_zone_i + 2'h1;
			default:    ;
		endcase
	endtask : fire

	// verdict
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		nrst_i = 1'b0;
		{thermal_limit_i, overtemp_i, thermistor_zone_i, battery_zone_i} = '0;
		{charger_mode_i, supply_zone_i, battery_below_limit_i} = '0;
		{system_below_battery_i, battery_above_weak_i} = '0;
		{watchdog_enable_i, watchdog_period_select_i, watchdog_kick_i} = '0;
		repeat (10) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		host.tick(3);
		// reset values at the pins and in all three registers
		chk(fs2_pins, 8'h00);
		chk(system_rail_mv_o, `RAIL_BASE_MV);
		chk({sda_oe_n_o, irq_o, watchdog_expired_o}, 3'h4);
		for (int a = 8; a < 11; a++) begin
			host.rd_reg(a[7:0], rd, ok);
			chk({ok, rd}, 9'h100);
		end
		$display("test reset done");
		// every diode code and rail code, with the inputs that decide them
		for (int i = 0; i < 8; i++) begin
			system_below_battery_i <= rows[i].sbb;
			battery_above_weak_i <= rows[i].abw;
			battery_below_limit_i <= rows[i].bbl;
			host.wr_reg(DEV, `ADDR_FS2, rows[i].val, ok);
			host.tick(6);
			chk(fs2_pins, rows[i].val);
			chk(system_rail_mv_o,
				`RAIL_BASE_MV + `RAIL_STEP_MV * rows[i].val[2:0]);
			chk(ideal_diode_on_o, rows[i].dio);
			chk(charge_permit_o, rows[i].prm);
			host.rd_reg(`ADDR_FS2, rd, ok);
			chk({ok, rd}, {1'b1, rows[i].val});
		end
		$display("test settings done");
		// unused bit, read-only flags, unmapped place, foreign address
		host.wr_reg(DEV, `ADDR_IEN, 8'hFF, ok);
		host.rd_reg(`ADDR_IEN, rd, ok);
		chk(rd, 8'h7F);
		host.wr_reg(DEV, `ADDR_IACT, 8'h7F, ok);
		host.rd_reg(`ADDR_IACT, rd, ok);
		chk(rd, 8'h00);
		host.rd_reg(8'h20, rd, ok);
		chk({ok, rd}, 9'h100);
		host.wr_reg(DEV ^ 7'h01, `ADDR_FS2, 8'h55, ok);
		chk(ok, 1'b0);
		host.rd_reg(`ADDR_FS2, rd, ok);
		chk(rd, 8'h87);
		// burst read: controller ack fetches the next place
		host.rd_two(`ADDR_FS2, rd2, ok);
		chk(rd2, 16'h877F);
		chk(ok, 1'b1);
		$display("test access done");
		// each enabled source but the watchdog sets its own flag, cleared by reading
		for (int b = 0; b < 7; b++) begin
			if (b == `FLG_WD) continue;
			fire(b);
			host.tick(6);
			chk(irq_o, 1'b1);
			host.rd_reg(`ADDR_IACT, rd, ok);
			chk(rd, 8'h01 << b);
			thermal_limit_i <= 1'b0;
			overtemp_i <= 1'b0;
			host.rd_reg(`ADDR_IACT, rd, ok);
			chk({irq_o, rd}, 9'h000);
		end
		$display("test flags done");
		// watchdog alarm leads expiry by 2 or 4 seconds
		for (int p = 0; p < 2; p++) begin
			watchdog_period_select_i <= p[0];
			watchdog_enable_i <= 1'b1;
			t0 = 0;
			while (irq_o !== 1'b1 && t0 < 70 * SEC_CYC) begin
				host.tick(1);
				t0++;
			end
			t1 = 0;
			while (watchdog_expired_o !== 1'b1 && t1 < 6 * SEC_CYC) begin
				host.tick(1);
				t1++;
			end
			if (t1 == 6 * SEC_CYC) begin
				n_mismatch++;
				end_sim();
			end
			chk(t0 > (p ? 59 : 29) * SEC_CYC
				&& t0 <= (p ? 60 : 30) * SEC_CYC + 3, 1'b1);
			chk(t1 >= (p ? 4 : 2) * SEC_CYC - 2
				&& t1 <= (p ? 4 : 2) * SEC_CYC + 2, 1'b1);
			host.rd_reg(`ADDR_IACT, rd, ok);
			chk(rd, 8'h20);
			watchdog_kick_i <= 1'b1;
			watchdog_enable_i <= 1'b0;
			host.tick(1);
			watchdog_kick_i <= 1'b0;
			host.tick(4);
			chk({irq_o, watchdog_expired_o}, 2'h0);
		end
		$display("test watchdog done");
		// disabled sources leave no flag
		host.wr_reg(DEV, `ADDR_IEN, 8'h40, ok);
		fire(`FLG_OT);
		fire(`FLG_THR);
		host.tick(6);
		overtemp_i <= 1'b0;
		host.rd_reg(`ADDR_IACT, rd, ok);
		chk({irq_o, rd}, 9'h000);
		$display("test masking done");
		// reset in mid-run returns settings and enables to zero
		nrst_i <= 1'b0;
		host.tick(2);
		chk(fs2_pins, 8'h00);
		chk(system_rail_mv_o, `RAIL_BASE_MV);
		nrst_i <= 1'b1;
		host.tick(3);
		host.rd_reg(`ADDR_IEN, rd, ok);
		chk({ok, rd}, 9'h100);
		$display("test second reset done");
		end_sim();
	end
endmodule : test_charger_config_and_irq_regs
